/* File: hw/rts_regs.svh */
// offsets, field positions, reset values and timing counts of the serial front end
// What this block does
// - top digital trim bit is the sign; zero adds, one subtracts frequency
// - the two magnitude trim bits weigh 10 ppm and 20 ppm, summed
// - digital trim spans -30..+30 ppm in 10 ppm steps; minus zero is zero
// - analog trim is two's complement; code zero is 11.0 pF, 0.25 pF per step
// - status write of 02h in its own transfer sets the write enable latch at once
// - a later status write of exactly 06h sets both enable latches
// - then one to 8 control bytes start a nonvolatile write of up to 10 ms
// - writes to undefined control locations change nothing
// - finished nonvolatile write clears register enable; an aborted sequence keeps it
// - status write of all zeros clears both enable latches
// - reads between the steps leave latches and pending sequence alone
// - device is always slave; the master starts transfers and drives the clock
// - data changes only while clock is low, except start and stop
// - device ignores the bus until a start, data falling with clock high
// - every transfer ends with a stop, which returns the device to standby
// - transmitter releases data after eight bits; receiver acknowledges on the ninth
// - no acknowledge on bad slave byte, data while enable low, second status byte
// - in read mode continue on acknowledge, halt on no acknowledge
// - slave byte: 1010 array or 1101 control, select bits 111, last bit read
// - acknowledge the slave byte only if its top seven bits match
// - two-byte word address or an internal counter cleared to zero at reset
// - status register sits at 003Fh in the control space
// - both enable latches are volatile and come up cleared
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH

`define ID_ARRAY        7'h57
`define ID_CTL          7'h6F
`define TGT_CTL         4'hD
`define STAT_ADDR       16'h003F
`define DIG_TRIM_ADDR   16'h0013
`define ANA_TRIM_ADDR   16'h0012
`define STAT_WEL_VAL    8'h02
`define STAT_BOTH_VAL   8'h06
`define STAT_CLR_VAL    8'h00
`define DIG_TRIM_RST    3'h0
`define ANA_TRIM_RST    6'h00
`define TRIM_STEP_LOW   6'h0A
`define TRIM_STEP_HIGH  6'h14
`define CAP_BASE_QPF    8'h2C
`define ARRAY_READ_VAL  8'hFF
`define CLK_HZ          10000000
`define NV_WRITE_MS     10
`define NV_WRITE_CYC    ((`NV_WRITE_MS * `CLK_HZ) / 1000)

`endif

/* File: hw/rts_pkg.sv */
// types shared by the serial front end
package rts_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK
    } rts_state_t;

    typedef enum logic [1:0] {
        PH_SLAVE, PH_WA1, PH_WA2, PH_DATA
    } rts_phase_t;

    typedef struct packed {
        logic signed [5:0] ppm;
        logic        [7:0] cap_qpf;
    } rts_trim_t;
endpackage

/* File: hw/rts_serial_slave.sv */
// two-wire slave front end with enable latches, trim fields and write timer
`timescale 1ns/1ps
`include "rts_regs.svh"

module rts_serial_slave
    import rts_pkg::*;
#(
    parameter int NV_WRITE_CYC = `NV_WRITE_CYC
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      link_clk,
    input  wire logic      scl_i,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe_n,
    output rts_trim_t      trim_o,
    output logic           nv_busy
);

    logic        scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic        scl_rise, scl_fall, start_c, stop_c;
    rts_state_t  st_q;
    rts_phase_t  ph_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic        rd_q, ctl_q;
    logic [15:0] addr_q;
    logic        write_enable_latch_q, register_write_enable_latch_q, rtc_fail_q;
    logic        stat_pend_q;
    logic [7:0]  stat_val_q;
    logic        ctl_wr_q, dig_hit_q, ana_hit_q;
    logic [2:0]  dig_stg_q, digital_freq_trim_q;
    logic [5:0]  ana_stg_q, analog_load_trim_q;
    logic        nv_wait_q, nv_req_t_q;
    logic        dn_m, dn_s, dn_p, done_edge;
    logic        rq_m, rq_s, rq_p;
    logic [16:0] nv_cnt_q;
    logic        done_t_q;
    logic        byte_done, id_ok, is_stat, ack_now, ld_tx, data_ok;
    logic [7:0]  rd_byte;
    logic [5:0]  trim_mag;

    assign sda_o = 1'h0;

    // first stage feeds only the second stage
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m <= 1'h1;
            scl_s <= 1'h1;
            scl_p <= 1'h1;
            sda_m <= 1'h1;
            sda_s <= 1'h1;
            sda_p <= 1'h1;
            dn_m  <= 1'h0;
            dn_s  <= 1'h0;
            dn_p  <= 1'h0;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_p <= sda_s;
            dn_m  <= done_t_q;
            dn_s  <= dn_m;
            dn_p  <= dn_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_c   = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_c    = scl_s & scl_p & ~sda_p & sda_s;
    assign done_edge = dn_s ^ dn_p;

    assign byte_done = (st_q == ST_RX) & scl_fall & (cnt_q == 4'h8);
    assign id_ok     = (sh_q[7:1] == `ID_ARRAY) | (sh_q[7:1] == `ID_CTL);
    assign is_stat   = ctl_q & (addr_q == `STAT_ADDR);
    assign data_ok   = byte_done & (ph_q == PH_DATA) & ack_now;
    assign ld_tx     = scl_fall & (((st_q == ST_ACK) & (ph_q == PH_SLAVE) & rd_q)
                                   | (st_q == ST_TXACK));

    // busy device answers nothing until the write timer is done
    always_comb begin
        case (ph_q)
            PH_SLAVE: ack_now = id_ok & ~nv_wait_q;
            PH_WA1:   ack_now = 1'h1;
            PH_WA2:   ack_now = 1'h1;
            PH_DATA:  ack_now = is_stat ? ~stat_pend_q : write_enable_latch_q;
            default:  ack_now = 1'h0;
        endcase
    end

    // array contents are not held here; array reads return a fixed byte
    always_comb begin
        rd_byte = 8'h00;
        if (!ctl_q) begin
            rd_byte = `ARRAY_READ_VAL;
        end else if (addr_q == `STAT_ADDR) begin
            rd_byte = {5'h00, register_write_enable_latch_q, write_enable_latch_q,
                       rtc_fail_q};
        end else if (addr_q == `DIG_TRIM_ADDR) begin
            rd_byte = {5'h00, digital_freq_trim_q};
        end else if (addr_q == `ANA_TRIM_ADDR) begin
            rd_byte = {2'h0, analog_load_trim_q};
        end
    end

    // bit-level protocol engine; the master owns the clock
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= ST_IDLE;
            ph_q     <= PH_SLAVE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            rd_q     <= 1'h0;
            ctl_q    <= 1'h0;
            addr_q   <= 16'h0000;
            sda_oe_n <= 1'h1;
        end else if (start_c) begin
            st_q     <= ST_RX;
            ph_q     <= PH_SLAVE;
            cnt_q    <= 4'h0;
            sda_oe_n <= 1'h1;
        end else if (stop_c) begin
            st_q     <= ST_IDLE;
            sda_oe_n <= 1'h1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    sda_oe_n <= 1'h1;
                end
                ST_RX: begin
                    if (scl_rise && cnt_q != 4'h8) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        if (ack_now) begin
                            sda_oe_n <= 1'h0;
                            st_q     <= ST_ACK;
                        end else begin
                            st_q     <= ST_IDLE;
                        end
                        case (ph_q)
                            PH_SLAVE: begin
                                ctl_q <= (sh_q[7:4] == `TGT_CTL);
                                rd_q  <= sh_q[0];
                            end
                            PH_WA1:  addr_q[15:8] <= sh_q;
                            PH_WA2:  addr_q[7:0]  <= sh_q;
                            PH_DATA: begin
                                // pages roll over: 8 bytes in control space, 128 in array
                                if (ack_now && !is_stat) begin
                                    addr_q <= ctl_q ? {addr_q[15:3], addr_q[2:0] + 3'h1}
                                                    : {addr_q[15:7], addr_q[6:0] + 7'h01};
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ST_ACK: begin
                    if (ld_tx) begin
                        sda_oe_n <= rd_byte[7];
                        sh_q     <= {rd_byte[6:0], 1'h0};
                        cnt_q    <= 4'h1;
                        addr_q   <= addr_q + 16'h0001;
                        st_q     <= ST_TX;
                    end else if (scl_fall) begin
                        sda_oe_n <= 1'h1;
                        cnt_q    <= 4'h0;
                        st_q     <= ST_RX;
                        ph_q     <= (ph_q == PH_SLAVE) ? PH_WA1 :
                                    (ph_q == PH_WA1) ? PH_WA2 : PH_DATA;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            sda_oe_n <= 1'h1;
                            st_q     <= ST_TXACK;
                        end else begin
                            sda_oe_n <= sh_q[7];
                            sh_q     <= {sh_q[6:0], 1'h0};
                            cnt_q    <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise && sda_s) begin
                        st_q <= ST_IDLE;
                    end else if (ld_tx) begin
                        sda_oe_n <= rd_byte[7];
                        sh_q     <= {rd_byte[6:0], 1'h0};
                        cnt_q    <= 4'h1;
                        addr_q   <= addr_q + 16'h0001;
                        st_q     <= ST_TX;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // enable latches, control-byte staging and commit at stop
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch_q          <= 1'h0;
            register_write_enable_latch_q <= 1'h0;
            rtc_fail_q          <= 1'h1;
            stat_pend_q         <= 1'h0;
            stat_val_q          <= 8'h00;
            ctl_wr_q            <= 1'h0;
            dig_hit_q           <= 1'h0;
            ana_hit_q           <= 1'h0;
            dig_stg_q           <= `DIG_TRIM_RST;
            ana_stg_q           <= `ANA_TRIM_RST;
            digital_freq_trim_q <= `DIG_TRIM_RST;
            analog_load_trim_q  <= `ANA_TRIM_RST;
            nv_wait_q           <= 1'h0;
            nv_req_t_q          <= 1'h0;
        end else begin
            if (done_edge) begin
                register_write_enable_latch_q <= 1'h0;
                nv_wait_q <= 1'h0;
            end
            if (start_c) begin
                // repeated start abandons staged bytes but keeps the latches
                stat_pend_q <= 1'h0;
                ctl_wr_q    <= 1'h0;
                dig_hit_q   <= 1'h0;
                ana_hit_q   <= 1'h0;
            end else if (stop_c) begin
                stat_pend_q <= 1'h0;
                ctl_wr_q    <= 1'h0;
                dig_hit_q   <= 1'h0;
                ana_hit_q   <= 1'h0;
                if (stat_pend_q) begin
                    // other data patterns are ignored
                    if (stat_val_q == `STAT_WEL_VAL) begin
                        write_enable_latch_q          <= 1'h1;
                        register_write_enable_latch_q <= 1'h0;
                    end else if (stat_val_q == `STAT_BOTH_VAL && write_enable_latch_q) begin
                        write_enable_latch_q          <= 1'h1;
                        register_write_enable_latch_q <= 1'h1;
                    end else if (stat_val_q == `STAT_CLR_VAL) begin
                        write_enable_latch_q          <= 1'h0;
                        register_write_enable_latch_q <= 1'h0;
                    end
                end
                if (ctl_wr_q) begin
                    if (dig_hit_q) begin
                        digital_freq_trim_q <= dig_stg_q;
                    end
                    if (ana_hit_q) begin
                        analog_load_trim_q <= ana_stg_q;
                    end
                    rtc_fail_q <= 1'h0;
                    nv_wait_q  <= 1'h1;
                    nv_req_t_q <= ~nv_req_t_q;
                end
            end else if (data_ok) begin
                if (is_stat) begin
                    stat_pend_q <= 1'h1;
                    stat_val_q  <= sh_q;
                end else if (ctl_q && register_write_enable_latch_q) begin
                    // undefined control addresses stage nothing and start no write cycle
                    ctl_wr_q <= ctl_wr_q | (addr_q == `DIG_TRIM_ADDR)
                                | (addr_q == `ANA_TRIM_ADDR);
                    if (addr_q == `DIG_TRIM_ADDR) begin
                        dig_hit_q <= 1'h1;
                        dig_stg_q <= sh_q[2:0];
                    end
                    if (addr_q == `ANA_TRIM_ADDR) begin
                        ana_hit_q <= 1'h1;
                        ana_stg_q <= sh_q[5:0];
                    end
                end
            end
        end
    end

    // trim decode, registered toward the oscillator
    assign trim_mag = (digital_freq_trim_q[1] ? `TRIM_STEP_LOW : 6'h00)
                    + (digital_freq_trim_q[0] ? `TRIM_STEP_HIGH : 6'h00);

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_o <= {6'h00, `CAP_BASE_QPF};
        end else begin
            trim_o.ppm     <= digital_freq_trim_q[2] ? 6'h00 - trim_mag : trim_mag;
            trim_o.cap_qpf <= `CAP_BASE_QPF
                            + {{2{analog_load_trim_q[5]}}, analog_load_trim_q};
        end
    end

    // nonvolatile write timer on the system clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rq_m     <= 1'h0;
            rq_s     <= 1'h0;
            rq_p     <= 1'h0;
            nv_cnt_q <= 17'h00000;
            nv_busy  <= 1'h0;
            done_t_q <= 1'h0;
        end else begin
            rq_m <= nv_req_t_q;
            rq_s <= rq_m;
            rq_p <= rq_s;
            if (rq_s ^ rq_p) begin
                nv_cnt_q <= 17'(NV_WRITE_CYC - 1);
                nv_busy  <= 1'h1;
            end else if (nv_busy) begin
                if (nv_cnt_q == 17'h00000) begin
                    nv_busy  <= 1'h0;
                    done_t_q <= ~done_t_q;
                end else begin
                    nv_cnt_q <= nv_cnt_q - 17'h00001;
                end
            end
        end
    end

    sequence s_released;
        st_q == ST_IDLE && sda_oe_n;
    endsequence

    sequence s_both_latch(logic w, logic r);
        write_enable_latch_q == w && register_write_enable_latch_q == r;
    endsequence

    property p_slave_nack;
        @(posedge link_clk) disable iff (!rst_n)
        byte_done && ph_q == PH_SLAVE && !id_ok |=> s_released;
    endproperty
    a_slave_nack: assert property (p_slave_nack) else $error("bad slave byte acked");

    property p_data_nack;
        @(posedge link_clk) disable iff (!rst_n)
        byte_done && ph_q == PH_DATA && !is_stat && !write_enable_latch_q |=> s_released;
    endproperty
    a_data_nack: assert property (p_data_nack) else $error("data acked with latch low");

    property p_idle_quiet;
        @(posedge link_clk) disable iff (!rst_n)
        st_q == ST_IDLE && !start_c |=> sda_oe_n;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("line driven while idle");

    property p_change_low;
        @(posedge link_clk) disable iff (!rst_n)
        $changed(sda_oe_n) && !$past(start_c) && !$past(stop_c) |-> !scl_s;
    endproperty
    a_change_low: assert property (p_change_low)
        else $error("data moved with clock high");

    property p_stat_clear;
        @(posedge link_clk) disable iff (!rst_n)
        stop_c && stat_pend_q && stat_val_q == `STAT_CLR_VAL |=> s_both_latch(1'h0, 1'h0);
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("zero write kept a latch");

    property p_stat_both;
        @(posedge link_clk) disable iff (!rst_n)
        stop_c && stat_pend_q && stat_val_q == `STAT_BOTH_VAL && write_enable_latch_q
            |=> s_both_latch(1'h1, 1'h1);
    endproperty
    a_stat_both: assert property (p_stat_both)
        else $error("06h write did not set latches");

    property p_done_clear;
        @(posedge link_clk) disable iff (!rst_n)
        done_edge |=> !register_write_enable_latch_q && !nv_wait_q;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("latch kept after write");

    property p_read_keep;
        @(posedge link_clk) disable iff (!rst_n)
        st_q == ST_TX |=> $stable(register_write_enable_latch_q) && $stable(ctl_wr_q);
    endproperty
    a_read_keep: assert property (p_read_keep)
        else $error("read disturbed write sequence");

    property p_minus_zero;
        @(posedge link_clk) disable iff (!rst_n)
        digital_freq_trim_q == 3'h4 |=> trim_o.ppm == 6'sh00;
    endproperty
    a_minus_zero: assert property (p_minus_zero)
        else $error("negative zero trim not zero");

    property p_nv_hold;
        @(posedge clk) disable iff (!rst_n)
        $rose(nv_busy) |-> nv_busy [*8];
    endproperty
    a_nv_hold: assert property (p_nv_hold) else $error("write timer ended early");

endmodule // rts_serial_slave

/* File: test/rts_i2c_master.sv */
// behavioural two-wire master for the serial front end
`timescale 1ns/1ps

module rts_i2c_master #(
    parameter int Q = 3
) (
    input  wire logic link_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    // one quarter bit, then the lines take their new levels
    task automatic put(input logic c, input logic d);
        repeat (Q) @(negedge link_clk);
        scl   = c;
        sda_m = d;
    endtask
    task automatic bit_w(input logic b);
        put(1'b0, b);
        put(1'b1, b);
        put(1'b1, b);
        put(1'b0, b);
    endtask
    // released line reads high through the pull-up
    task automatic bit_r(output logic r);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b1);
        r = sda;
        put(1'b0, 1'b1);
    endtask
    task automatic start();
        put(scl, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask
    task automatic stop();
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_w(b[i]);
        bit_r(r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_r(b[i]);
        bit_w(~ack);
    endtask
endmodule // rts_i2c_master

/* File: test/testbench.sv */
// self-checking bench for the serial front end
`timescale 1ns/1ps
`include "rts_regs.svh"

`define CHK(got, exp, msg) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("mismatch at %0t: %s", $time, msg); \
    end \
end

module testbench
    import rts_pkg::*;
;
    localparam int NV = 400;
    logic      clk = 1'b0;
    logic      link_clk = 1'b0;
    logic      rst_n = 1'b0;
    logic      scl;
    logic      sda_m;
    logic      sda_o;
    logic      sda_oe_n;
    logic      nv_busy;
    logic      rf = 1'b1;
    rts_trim_t trim_o;
    int        failures = 0;
    int        samples_checked = 0;
    wire       sda = sda_m & (sda_oe_n | sda_o);

    rts_serial_slave #(.NV_WRITE_CYC(NV)) dut_u (
        .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .trim_o(trim_o), .nv_busy(nv_busy)
    );
    rts_i2c_master m_u (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    always #50 clk = ~clk;
    // odd offset keeps the link clock out of phase with clk
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    task automatic conclude();
        $display("checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] sb, input logic [15:0] a, input logic [7:0] d0, d1,
                      input int n, input logic stp, output logic ok);
        logic k;
        m_u.start();
        m_u.wbyte(sb, ok);
        m_u.wbyte(a[15:8], k);
        ok &= k;
        m_u.wbyte(a[7:0], k);
        ok &= k;
        for (int i = 0; i < n; i++) begin
            m_u.wbyte(i == 0 ? d0 : d1, k);
            ok &= k;
        end
        if (stp) m_u.stop();
    endtask

    task automatic rd(input logic [7:0] sb, input logic [15:0] a, output logic [15:0] b);
        logic k;
        m_u.start();
        m_u.wbyte(sb, k);
        m_u.wbyte(a[15:8], k);
        m_u.wbyte(a[7:0], k);
        m_u.start();
        m_u.wbyte(sb | 8'h01, k);
        `CHK(k, 1'b1, "read slave refused")
        m_u.rbyte(1'b1, b[15:8]);
        m_u.rbyte(1'b0, b[7:0]);
        m_u.stop();
    endtask

    task automatic stat(input logic [7:0] e);
        logic [15:0] b;
        rd(8'hDE, `STAT_ADDR, b);
        `CHK(b, {e, 8'h00}, "status")
    endtask

    // busy device refuses its slave byte until the write cycle ends
    task automatic poll();
        logic k;
        int   i;
        for (i = 0; i < 60; i++) begin
            m_u.start();
            if (i == 0) `CHK(nv_busy, 1'b1, "timer idle")
            m_u.wbyte(8'hDE, k);
            m_u.stop();
            if (i == 0) `CHK(k, 1'b0, "acked while busy")
            if (k) break;
        end
        if (i == 60) begin
            failures++;
            conclude();
        end
    endtask

    task automatic t_idle();
        logic        k;
        logic [7:0]  bad [4] = '{8'hDC, 8'hAA, 8'h5E, 8'hDA};
        logic [15:0] b;
        `CHK({sda_oe_n, nv_busy, sda_o}, 3'h4, "outputs at reset")
        `CHK(trim_o, {6'h00, `CAP_BASE_QPF}, "trim at reset")
        for (int i = 7; i >= 0; i--) m_u.bit_w(bad[0][i]);
        m_u.bit_r(k);
        `CHK(k, 1'b1, "ack without start")
        foreach (bad[i]) begin
            m_u.start();
            m_u.wbyte(bad[i], k);
            m_u.stop();
            `CHK(k, 1'b0, "foreign slave byte")
        end
        wr(8'hAE, 16'h0000, 8'h5A, 8'h00, 1, 1'b1, k);
        `CHK(k, 1'b0, "array data with latch low")
        rd(8'hAE, 16'h0000, b);
        `CHK(b, 16'hFFFF, "array read")
        stat(8'h01);
        $display("test idle done");
    endtask

    task automatic t_trim();
        logic [7:0]        ana [8] = '{8'h00, 8'h01, 8'h1F, 8'h21, 8'h3F, 8'h10, 8'h2A, 8'h05};
        logic [15:0]       b;
        logic              k;
        logic signed [5:0] ep;
        int                m;
        logic [7:0]        ec;
        for (int d = 0; d < 8; d++) begin
            wr(8'hDE, `STAT_ADDR, `STAT_WEL_VAL, 8'h00, 1, 1'b1, k);
            stat({6'h00, 1'b1, rf});
            wr(8'hDE, `STAT_ADDR, `STAT_BOTH_VAL, 8'h00, 1, 1'b1, k);
            stat({5'h00, 2'h3, rf});
            wr(8'hDE, `ANA_TRIM_ADDR, ana[d], 8'(d), 2, 1'b1, k);
            `CHK(k, 1'b1, "trim bytes refused")
            poll();
            rf = 1'b0;
            stat(8'h02);
            m = (d[1] ? 10 : 0) + (d[0] ? 20 : 0);
            ep = 6'(d[2] ? -m : m);
            `CHK(trim_o.ppm, ep, "digital trim")
            ec = 8'($signed({1'b0, `CAP_BASE_QPF}) + $signed(ana[d][5:0]));
            `CHK(trim_o.cap_qpf, ec, "load trim")
            rd(8'hDE, `ANA_TRIM_ADDR, b);
            `CHK(b, {ana[d], 8'(d)}, "trim readback")
        end
        $display("test trim done");
    endtask

    task automatic t_abort();
        logic k;
        wr(8'hDE, `STAT_ADDR, `STAT_WEL_VAL, 8'h00, 1, 1'b1, k);
        wr(8'hDE, `STAT_ADDR, `STAT_BOTH_VAL, 8'h00, 1, 1'b1, k);
        wr(8'hDE, `DIG_TRIM_ADDR, 8'h01, 8'h00, 1, 1'b0, k);
        stat(8'h06);
        `CHK({nv_busy, trim_o}, {1'b0, 6'h22, 8'h31}, "aborted write landed")
        wr(8'hDE, 16'h0030, 8'hFF, 8'h00, 1, 1'b1, k);
        repeat (NV + 100) @(negedge clk);
        `CHK({nv_busy, trim_o}, {1'b0, 6'h22, 8'h31}, "undefined write landed")
        stat(8'h06);
        wr(8'hDE, `STAT_ADDR, `STAT_CLR_VAL, 8'h00, 1, 1'b1, k);
        stat(8'h00);
        wr(8'hDE, `DIG_TRIM_ADDR, 8'h01, 8'h00, 1, 1'b1, k);
        `CHK(k, 1'b0, "data with latch low")
        wr(8'hDE, `STAT_ADDR, `STAT_CLR_VAL, `STAT_CLR_VAL, 2, 1'b1, k);
        `CHK(k, 1'b0, "second status byte")
        wr(8'hDE, `STAT_ADDR, `STAT_BOTH_VAL, 8'h00, 1, 1'b1, k);
        stat(8'h00);
        $display("test abort done");
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge link_clk);
        t_idle();
        t_trim();
        t_abort();
        conclude();
    end

    // hang guard just under the run budget
    initial begin
        #9500000;
        failures++;
        conclude();
    end
endmodule // testbench
